//--- shared/isu_pkg.sv
package isu_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int FCNT_W   = 20;
    localparam int FMAX_W   = 16;
    localparam int FLOW_W   = 4;
    localparam int OCNT_W   = 20;
    localparam int ADDR_W   = 48;
    localparam int LAT_W    = 16;
    localparam int LFSR_W   = 7;

    // ------------------------------------------------------------
    // reset values and constants
    // ------------------------------------------------------------
    localparam logic [FCNT_W-1:0] FCNT_RST  = 20'h0_0000;
    localparam logic [OCNT_W-1:0] OCNT_RST  = 20'h0_0000;
    localparam logic [LAT_W-1:0]  LAT_RST   = 16'h0000;
    localparam logic [LAT_W-1:0]  LAT_MAX   = 16'hFFFF;
    localparam logic [LFSR_W-1:0] LFSR_SEED = 7'h01;
    localparam logic [ADDR_W-1:0] ADDR_RST  = 48'h0000_0000_0000;

    // ------------------------------------------------------------
    // op type encoding
    // ------------------------------------------------------------
    localparam logic [1:0] OPT_OTHER  = 2'h0;
    localparam logic [1:0] OPT_BRANCH = 2'h1;
    localparam logic [1:0] OPT_RETURN = 2'h2;
    localparam logic [1:0] OPT_MEM    = 2'h3;

    typedef enum logic [1:0] {
        ISU_IDLE,
        ISU_COUNT,
        ISU_TAGGED,
        ISU_DONE
    } isu_state_type;

    function automatic logic [LAT_W-1:0] isu_sat_inc(input logic [LAT_W-1:0] v);
        return (v == LAT_MAX) ? v : v + 16'h0001;
    endfunction

endpackage

//--- hw/isu_lfsr.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// 7-bit maximum-period lfsr, x^7 + x^6 + 1
// ------------------------------------------------------------
module isu_lfsr
    import isu_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic              nrst_i,
    output logic [LFSR_W-1:0]      value_o
);
    logic [LFSR_W-1:0] lfsr_reg;

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            lfsr_reg <= LFSR_SEED;
        end else begin
            lfsr_reg <= {lfsr_reg[5:0], lfsr_reg[6] ^ lfsr_reg[5]};
        end
    end

    assign value_o = lfsr_reg;
endmodule

//--- hw/isu_top.sv
`timescale 1ns/10ps
module isu_top
    import isu_pkg::*;
(
    input  wire logic                MCLK_I,
    input  wire logic                NRST_I,
    // fetch control
    input  wire logic                F_EN_I,
    input  wire logic [FMAX_W-1:0]   F_MAX_I,
    input  wire logic                F_RAND_I,
    input  wire logic                F_CLR_I,
    // fetch pipeline
    input  wire logic                F_START_I,
    input  wire logic [ADDR_W-1:0]   F_VADDR_I,
    input  wire logic                F_PA_VALID_I,
    input  wire logic [ADDR_W-1:0]   F_PADDR_I,
    input  wire logic [1:0]          F_PGSZ_I,
    input  wire logic                F_L1TLB_MISS_I,
    input  wire logic                F_L2TLB_MISS_I,
    input  wire logic                F_IC_MISS_I,
    input  wire logic                F_DONE_I,
    input  wire logic                F_ABORT_I,
    // op control
    input  wire logic                O_EN_I,
    input  wire logic [OCNT_W-1:0]   O_MAX_I,
    input  wire logic                O_CLR_I,
    // op pipeline
    input  wire logic                O_ISSUE_I,
    input  wire logic [ADDR_W-1:0]   O_PARENT_I,
    input  wire logic [1:0]          O_TYPE_I,
    input  wire logic                O_MISPRED_I,
    input  wire logic                O_DC_MISS_I,
    input  wire logic                O_DC_FILL_I,
    input  wire logic [ADDR_W-1:0]   O_LS_VADDR_I,
    input  wire logic [ADDR_W-1:0]   O_LS_PADDR_I,
    input  wire logic                O_LS_VALID_I,
    input  wire logic                O_RETIRE_I,
    // fetch results
    output logic                     F_IRQ_O,
    output logic                     F_VALID_O,
    output logic                     F_ARMED_O,
    output logic [FCNT_W-1:0]        F_CNT_O,
    output logic [ADDR_W-1:0]        F_RES_VADDR_O,
    output logic [ADDR_W-1:0]        F_RES_PADDR_O,
    output logic                     F_RES_PA_VALID_O,
    output logic [1:0]               F_RES_PGSZ_O,
    output logic [3:0]               F_RES_FLAGS_O,
    output logic [LAT_W-1:0]         F_RES_LAT_O,
    // op results
    output logic                     O_IRQ_O,
    output logic                     O_VALID_O,
    output logic                     O_ARMED_O,
    output logic [ADDR_W-1:0]        O_RES_PARENT_O,
    output logic [1:0]               O_RES_TYPE_O,
    output logic [1:0]               O_RES_FLAGS_O,
    output logic [LAT_W-1:0]         O_RES_TAG_RET_O,
    output logic [LAT_W-1:0]         O_RES_DC_LAT_O,
    output logic [ADDR_W-1:0]        O_RES_LS_VADDR_O,
    output logic [ADDR_W-1:0]        O_RES_LS_PADDR_O
);

    // ------------------------------------------------------------
    // lfsr
    // ------------------------------------------------------------
    logic [LFSR_W-1:0] lfsr_val;

    isu_lfsr isu_lfsr_i (
        .clk_i   (MCLK_I),
        .nrst_i  (NRST_I),
        .value_o (lfsr_val)
    );

    // ------------------------------------------------------------
    // fetch channel
    // ------------------------------------------------------------
    isu_state_type     f_state_reg;
    logic [FCNT_W-1:0] f_cnt_reg;
    logic [FCNT_W-1:0] f_max;
    logic [LAT_W-1:0]  f_lat_reg;
    logic              f_inflight_reg;
    logic              f_end;

    assign f_max = {F_MAX_I, 4'h0};
    assign f_end = F_DONE_I | F_ABORT_I;

    always_ff @(posedge MCLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            f_state_reg <= ISU_IDLE;
        end else begin
            unique case (f_state_reg)
                ISU_IDLE: begin
                    if (F_EN_I) begin
                        f_state_reg <= ISU_COUNT;
                    end
                end
                ISU_COUNT: begin
                    if (!F_EN_I) begin
                        f_state_reg <= ISU_IDLE;
                    end else if (f_cnt_reg == f_max && F_START_I && !f_inflight_reg) begin
                        f_state_reg <= ISU_TAGGED;
                    end
                end
                ISU_TAGGED: begin
                    if (f_end) begin
                        f_state_reg <= ISU_DONE;
                    end
                end
                ISU_DONE: begin
                    if (F_CLR_I) begin
                        f_state_reg <= ISU_IDLE;
                    end
                end
            endcase
        end
    end

    // a fetch started but not yet ended, so the end pulse is not misattributed
    always_ff @(posedge MCLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            f_inflight_reg <= 1'b0;
        end else if (F_START_I) begin
            f_inflight_reg <= 1'b1;
        end else if (f_end) begin
            f_inflight_reg <= 1'b0;
        end
    end

    always_ff @(posedge MCLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            f_cnt_reg <= FCNT_RST;
        end else if (F_CLR_I && f_state_reg != ISU_COUNT) begin
            f_cnt_reg <= F_RAND_I ? {16'h0000, lfsr_val[3:0]} : FCNT_RST;
        end else if (f_state_reg == ISU_COUNT && F_EN_I) begin
            if (f_cnt_reg == f_max) begin
                if (F_START_I && !f_inflight_reg) begin
                    f_cnt_reg <= FCNT_RST;
                end
            end else if (F_DONE_I) begin
                f_cnt_reg <= f_cnt_reg + 20'h0_0001;
            end
        end
    end

    always_ff @(posedge MCLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            F_RES_VADDR_O    <= ADDR_RST;
            F_RES_PADDR_O    <= ADDR_RST;
            F_RES_PA_VALID_O <= 1'b0;
            F_RES_PGSZ_O     <= 2'h0;
            F_RES_FLAGS_O    <= 4'h0;
            f_lat_reg        <= LAT_RST;
        end else if (f_state_reg == ISU_COUNT && F_EN_I && f_cnt_reg == f_max
                     && F_START_I && !f_inflight_reg) begin
            F_RES_VADDR_O    <= F_VADDR_I;
            F_RES_PADDR_O    <= ADDR_RST;
            F_RES_PA_VALID_O <= 1'b0;
            F_RES_PGSZ_O     <= 2'h0;
            F_RES_FLAGS_O    <= 4'h0;
            f_lat_reg        <= LAT_RST;
        end else if (f_state_reg == ISU_TAGGED) begin
            f_lat_reg <= isu_sat_inc(f_lat_reg);
            if (F_PA_VALID_I && !F_RES_PA_VALID_O) begin
                F_RES_PADDR_O    <= F_PADDR_I;
                F_RES_PGSZ_O     <= F_PGSZ_I;
                F_RES_PA_VALID_O <= 1'b1;
            end
            // flags: [0] complete [1] l1 itlb miss [2] l2 itlb miss [3] ic miss
            F_RES_FLAGS_O <= F_RES_FLAGS_O
                           | {F_IC_MISS_I, F_L2TLB_MISS_I, F_L1TLB_MISS_I, F_DONE_I};
        end
    end

    always_ff @(posedge MCLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            F_IRQ_O   <= 1'b0;
            F_VALID_O <= 1'b0;
            F_ARMED_O <= 1'b0;
            F_CNT_O   <= FCNT_RST;
            F_RES_LAT_O <= LAT_RST;
        end else begin
            F_IRQ_O   <= (f_state_reg == ISU_TAGGED) && f_end;
            F_VALID_O <= (f_state_reg == ISU_DONE && !F_CLR_I)
                       || (f_state_reg == ISU_TAGGED && f_end);
            F_ARMED_O <= (f_state_reg == ISU_COUNT);
            F_CNT_O   <= f_cnt_reg;
            if (f_state_reg == ISU_TAGGED) begin
                F_RES_LAT_O <= isu_sat_inc(f_lat_reg);
            end
        end
    end

    // ------------------------------------------------------------
    // op channel
    // ------------------------------------------------------------
    isu_state_type     o_state_reg;
    logic [OCNT_W-1:0] o_cnt_reg;
    logic              o_pend_reg;
    logic              o_miss_reg;
    logic              o_take;

    assign o_take = (o_state_reg == ISU_COUNT) && O_EN_I && O_ISSUE_I
                    && (o_pend_reg || o_cnt_reg == O_MAX_I);

    always_ff @(posedge MCLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            o_state_reg <= ISU_IDLE;
        end else begin
            unique case (o_state_reg)
                ISU_IDLE: begin
                    if (O_EN_I) begin
                        o_state_reg <= ISU_COUNT;
                    end
                end
                ISU_COUNT: begin
                    if (!O_EN_I) begin
                        o_state_reg <= ISU_IDLE;
                    end else if (o_take) begin
                        o_state_reg <= ISU_TAGGED;
                    end
                end
                ISU_TAGGED: begin
                    if (O_RETIRE_I) begin
                        o_state_reg <= ISU_DONE;
                    end
                end
                ISU_DONE: begin
                    if (O_CLR_I) begin
                        o_state_reg <= ISU_IDLE;
                    end
                end
            endcase
        end
    end

    // counter reached max with no op issuing: tag the next op issued
    always_ff @(posedge MCLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            o_cnt_reg  <= OCNT_RST;
            o_pend_reg <= 1'b0;
        end else if (O_CLR_I && o_state_reg != ISU_COUNT) begin
            o_cnt_reg  <= OCNT_RST;
            o_pend_reg <= 1'b0;
        end else if (o_state_reg == ISU_COUNT && O_EN_I) begin
            if (o_take) begin
                o_cnt_reg  <= OCNT_RST;
                o_pend_reg <= 1'b0;
            end else if (o_cnt_reg == O_MAX_I) begin
                o_pend_reg <= 1'b1;
            end else begin
                o_cnt_reg <= o_cnt_reg + 20'h0_0001;
            end
        end
    end

    always_ff @(posedge MCLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            O_RES_PARENT_O   <= ADDR_RST;
            O_RES_TYPE_O     <= OPT_OTHER;
            O_RES_FLAGS_O    <= 2'h0;
            O_RES_TAG_RET_O  <= LAT_RST;
            O_RES_DC_LAT_O   <= LAT_RST;
            O_RES_LS_VADDR_O <= ADDR_RST;
            O_RES_LS_PADDR_O <= ADDR_RST;
            o_miss_reg       <= 1'b0;
        end else if (o_take) begin
            O_RES_PARENT_O   <= O_PARENT_I;
            O_RES_TYPE_O     <= O_TYPE_I;
            O_RES_FLAGS_O    <= 2'h0;
            O_RES_TAG_RET_O  <= LAT_RST;
            O_RES_DC_LAT_O   <= LAT_RST;
            O_RES_LS_VADDR_O <= ADDR_RST;
            O_RES_LS_PADDR_O <= ADDR_RST;
            o_miss_reg       <= 1'b0;
        end else if (o_state_reg == ISU_TAGGED) begin
            O_RES_TAG_RET_O <= isu_sat_inc(O_RES_TAG_RET_O);
            // flags: [0] mispredict [1] dcache miss
            O_RES_FLAGS_O <= O_RES_FLAGS_O | {O_DC_MISS_I, O_MISPRED_I};
            if (O_DC_MISS_I) begin
                o_miss_reg <= 1'b1;
            end else if (O_DC_FILL_I) begin
                o_miss_reg <= 1'b0;
            end
            if (o_miss_reg || O_DC_MISS_I) begin
                O_RES_DC_LAT_O <= isu_sat_inc(O_RES_DC_LAT_O);
            end
            if (O_LS_VALID_I && O_RES_TYPE_O == OPT_MEM) begin
                O_RES_LS_VADDR_O <= O_LS_VADDR_I;
                O_RES_LS_PADDR_O <= O_LS_PADDR_I;
            end
        end
    end

    always_ff @(posedge MCLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            O_IRQ_O   <= 1'b0;
            O_VALID_O <= 1'b0;
            O_ARMED_O <= 1'b0;
        end else begin
            O_IRQ_O   <= (o_state_reg == ISU_TAGGED) && O_RETIRE_I;
            O_VALID_O <= (o_state_reg == ISU_DONE && !O_CLR_I)
                       || (o_state_reg == ISU_TAGGED && O_RETIRE_I);
            O_ARMED_O <= (o_state_reg == ISU_COUNT);
        end
    end

endmodule

//--- tb/isu_pipe.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// pipeline stand-in: fetches and ops
// ------------------------------------------------------------
module isu_pipe
    import isu_pkg::*;
(
    input  wire logic         clk_i,
    output logic              f_start_o,
    output logic [ADDR_W-1:0] f_va_o,
    output logic              f_pav_o,
    output logic [ADDR_W-1:0] f_pa_o,
    output logic [1:0]        f_pgsz_o,
    output logic [2:0]        f_miss_o,
    output logic              f_done_o,
    output logic              f_abort_o,
    output logic              o_issue_o,
    output logic [ADDR_W-1:0] o_par_o,
    output logic [1:0]        o_type_o,
    output logic [1:0]        o_ev_o,
    output logic              o_fill_o,
    output logic              o_lsv_o,
    output logic [ADDR_W-1:0] o_lsva_o,
    output logic [ADDR_W-1:0] o_lspa_o,
    output logic              o_ret_o
);
    initial begin
        {f_start_o, f_pav_o, f_done_o, f_abort_o, f_va_o, f_pa_o, f_pgsz_o, f_miss_o} = '0;
        {o_issue_o, o_lsv_o, o_fill_o, o_ret_o, o_par_o, o_type_o, o_ev_o} = '0;
        {o_lsva_o, o_lspa_o} = '0;
    end

    task automatic nxt(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    // released address, type and page-size lines show the inverse of their last value; strobes and event lines return to 0
    task automatic fetch(input logic [ADDR_W-1:0] va, pa, input logic [2:0] ev,
                         input int dur, input logic ab);
        nxt(1);
        f_start_o = 1'b1;
        f_va_o    = va;
        nxt(1);
        f_start_o = 1'b0;
        f_va_o    = ~va;
        f_pav_o   = 1'b1;
        f_pa_o    = pa;
        f_pgsz_o  = pa[1:0];
        f_miss_o  = ev;
        nxt(1);
        f_pav_o   = 1'b0;
        f_pa_o    = ~pa;
        f_pgsz_o  = ~pa[1:0];
        f_miss_o  = 3'h0;
        nxt(dur);
        f_done_o  = ~ab;
        f_abort_o = ab;
        nxt(1);
        f_done_o  = 1'b0;
        f_abort_o = 1'b0;
    endtask

    task automatic op(input logic [ADDR_W-1:0] par, va, pa, input logic [1:0] ty,
                      input int dc);
        nxt(1);
        o_issue_o = 1'b1;
        o_par_o   = par;
        o_type_o  = ty;
        nxt(1);
        o_issue_o = 1'b0;
        o_par_o   = ~par;
        o_type_o  = ~ty;
        o_lsv_o   = (ty == OPT_MEM);
        o_lsva_o  = va;
        o_lspa_o  = pa;
        o_ev_o    = {ty == OPT_MEM, ty == OPT_BRANCH || ty == OPT_RETURN};
        nxt(1);
        o_lsv_o   = 1'b0;
        o_lsva_o  = ~va;
        o_lspa_o  = ~pa;
        o_ev_o    = 2'h0;
        nxt(dc);
        o_fill_o  = (ty == OPT_MEM);
        nxt(1);
        o_fill_o  = 1'b0;
        o_ret_o   = 1'b1;
        nxt(1);
        o_ret_o   = 1'b0;
    endtask
endmodule

//--- tb/isu_top_assertions.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// port checker
// ------------------------------------------------------------
module isu_chk
    import isu_pkg::*;
(
    input wire logic              MCLK_I,
    input wire logic              NRST_I,
    input wire logic              F_EN_I,
    input wire logic              F_CLR_I,
    input wire logic              F_START_I,
    input wire logic              F_DONE_I,
    input wire logic              F_ABORT_I,
    input wire logic              O_CLR_I,
    input wire logic              O_RETIRE_I,
    input wire logic              F_IRQ_O,
    input wire logic              F_VALID_O,
    input wire logic              F_ARMED_O,
    input wire logic [FCNT_W-1:0] F_CNT_O,
    input wire logic [ADDR_W-1:0] F_RES_VADDR_O,
    input wire logic [3:0]        F_RES_FLAGS_O,
    input wire logic              O_IRQ_O,
    input wire logic              O_VALID_O,
    input wire logic [ADDR_W-1:0] O_RES_PARENT_O
);
    default clocking dc @(posedge MCLK_I); endclocking
    default disable iff (!NRST_I);

    f_irq_cause_a: assert property (F_IRQ_O |-> $past(F_DONE_I) || $past(F_ABORT_I))
        else $error("fetch irq without finish");
    f_comp_flag_a: assert property (
        F_IRQ_O |-> F_VALID_O && F_RES_FLAGS_O[0] == $past(F_DONE_I))
        else $error("fetch result flag wrong");
    f_hold_a: assert property (
        F_VALID_O && !F_CLR_I |=> F_VALID_O && !F_IRQ_O && $stable(F_RES_VADDR_O))
        else $error("fetch sample not held");
    f_cnt_cause_a: assert property (
        $changed(F_CNT_O) |-> $past(F_DONE_I, 2) || $past(F_CLR_I, 2)
        || $past(F_START_I, 2) || $past(F_DONE_I) || $past(F_CLR_I) || $past(F_START_I))
        else $error("fetch counter moved without cause");
    f_arm_en_a: assert property ($rose(F_ARMED_O) |-> $past(F_EN_I, 2))
        else $error("fetch armed while disabled");
    f_off_a: assert property (!F_EN_I [*2] |=> !F_ARMED_O)
        else $error("fetch armed after disable");
    o_irq_cause_a: assert property (O_IRQ_O |-> $past(O_RETIRE_I) && O_VALID_O)
        else $error("op irq without retire");
    o_hold_a: assert property (
        O_VALID_O && !O_CLR_I |=> O_VALID_O && !O_IRQ_O && $stable(O_RES_PARENT_O))
        else $error("op sample not held");

    c_abort: cover property (F_IRQ_O && !F_RES_FLAGS_O[0]);
    c_op: cover property (O_IRQ_O);
    c_clear: cover property (F_VALID_O && F_CLR_I);
endmodule

bind isu_top isu_chk isu_chk_i (.*);

//--- tb/test_isu_top.sv
`timescale 1ns/10ps
module test_isu_top
    import isu_pkg::*;
;
    logic              MCLK_I, NRST_I, F_EN_I, F_RAND_I, F_CLR_I, O_EN_I, O_CLR_I;
    logic              F_START_I, F_PA_VALID_I, F_L1TLB_MISS_I, F_L2TLB_MISS_I, F_IC_MISS_I;
    logic              F_DONE_I, F_ABORT_I, O_ISSUE_I, O_MISPRED_I, O_DC_MISS_I, O_DC_FILL_I;
    logic              O_LS_VALID_I, O_RETIRE_I, F_IRQ_O, F_VALID_O, F_ARMED_O;
    logic              F_RES_PA_VALID_O, O_IRQ_O, O_VALID_O, O_ARMED_O;
    logic [FMAX_W-1:0] F_MAX_I;
    logic [OCNT_W-1:0] O_MAX_I;
    logic [FCNT_W-1:0] F_CNT_O, cnt;
    logic [ADDR_W-1:0] F_VADDR_I, F_PADDR_I, O_PARENT_I, O_LS_VADDR_I, O_LS_PADDR_I, va0;
    logic [ADDR_W-1:0] F_RES_VADDR_O, F_RES_PADDR_O, O_RES_PARENT_O;
    logic [ADDR_W-1:0] O_RES_LS_VADDR_O, O_RES_LS_PADDR_O;
    logic [1:0]        F_PGSZ_I, O_TYPE_I, F_RES_PGSZ_O, O_RES_TYPE_O, O_RES_FLAGS_O;
    logic [3:0]        F_RES_FLAGS_O;
    logic [LAT_W-1:0]  F_RES_LAT_O, O_RES_TAG_RET_O, O_RES_DC_LAT_O;
    int                n_fail = 0, checked = 0, f_irqs = 0, o_irqs = 0, cycles = 0;

    isu_top isu_top_i (.*);
    isu_pipe isu_pipe_i (
        .clk_i(MCLK_I), .f_start_o(F_START_I), .f_va_o(F_VADDR_I), .f_pav_o(F_PA_VALID_I),
        .f_pa_o(F_PADDR_I), .f_pgsz_o(F_PGSZ_I), .f_done_o(F_DONE_I), .f_abort_o(F_ABORT_I),
        .f_miss_o({F_IC_MISS_I, F_L2TLB_MISS_I, F_L1TLB_MISS_I}), .o_issue_o(O_ISSUE_I),
        .o_par_o(O_PARENT_I), .o_type_o(O_TYPE_I), .o_ev_o({O_DC_MISS_I, O_MISPRED_I}),
        .o_fill_o(O_DC_FILL_I), .o_lsv_o(O_LS_VALID_I), .o_lsva_o(O_LS_VADDR_I),
        .o_lspa_o(O_LS_PADDR_I), .o_ret_o(O_RETIRE_I)
    );

    initial begin
        MCLK_I = 1'b0;
        forever #5 MCLK_I = ~MCLK_I;
    end

    // irq pulses counted away from the launching edge
    always @(negedge MCLK_I) begin
        f_irqs += int'(F_IRQ_O === 1'b1);
        o_irqs += int'(O_IRQ_O === 1'b1);
    end

    always @(posedge MCLK_I) begin
        cycles++;
        if (cycles == 5000) begin
            n_fail++;
            end_of_test();
        end
    end

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge MCLK_I);
        #1;
    endtask

    task automatic chk(input logic [ADDR_W-1:0] got, exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic rearm_f(input logic rnd);
        F_EN_I   = 1'b0;
        F_RAND_I = rnd;
        tick(1);
        F_CLR_I  = 1'b1;
        tick(1);
        F_CLR_I  = 1'b0;
        F_EN_I   = 1'b1;
        tick(2);
        f_irqs   = 0;
    endtask

    task automatic fsample(input logic [ADDR_W-1:0] va, pa, input logic [2:0] ev,
                           input logic ab);
        isu_pipe_i.fetch(va, pa, ev, 2, ab);
        tick(2);
        chk(f_irqs, 1);
        chk(F_RES_FLAGS_O, {ev, ~ab});
        chk(F_RES_VADDR_O, va);
        chk(F_RES_PADDR_O, pa);
        chk({F_RES_PA_VALID_O, F_RES_PGSZ_O}, {1'b1, pa[1:0]});
        chk(F_RES_LAT_O, 16'h0004);
    endtask

    initial begin
        {NRST_I, F_EN_I, F_RAND_I, F_CLR_I, O_EN_I, O_CLR_I} = '0;
        F_MAX_I = '0;
        O_MAX_I = '0;
        va0     = 48'h1234_5678_9ABC;
        tick(2);
        chk({F_IRQ_O, F_VALID_O, F_ARMED_O, O_IRQ_O, O_VALID_O, O_ARMED_O, F_CNT_O}, 0);
        NRST_I = 1'b1;
        F_EN_I = 1'b1;
        tick(2);
        chk(F_ARMED_O, 1'b1);
        fsample(va0, 48'h0FED_CBA9_8766, 3'h5, 1'b0);
        isu_pipe_i.fetch(~va0, 48'h0000_3333_4444, 3'h7, 1, 1'b0);
        tick(2);
        chk(f_irqs, 1);
        chk(F_RES_VADDR_O, va0);
        $display("test fetch_tag end");
        rearm_f(1'b0);
        chk(F_VALID_O, 1'b0);
        fsample(48'h0000_ABCD_0010, 48'h0000_0055_5501, 3'h2, 1'b1);
        $display("test fetch_abort end");
        F_MAX_I = 16'h0001;
        rearm_f(1'b0);
        repeat (16) isu_pipe_i.fetch(va0, va0, 3'h0, 0, 1'b0);
        tick(2);
        chk(f_irqs, 0);
        chk(F_CNT_O, 20'h0_0010);
        fsample(48'h0000_0000_5550, 48'h0000_0000_6663, 3'h1, 1'b0);
        $display("test fetch_count end");
        F_MAX_I = 16'h0000;
        rearm_f(1'b1);
        chk(F_CNT_O[FCNT_W-1:FLOW_W], 16'h0000);
        F_EN_I = 1'b0;
        tick(2);
        cnt = F_CNT_O;
        chk(F_ARMED_O, 1'b0);
        isu_pipe_i.fetch(va0, va0, 3'h0, 0, 1'b0);
        tick(2);
        chk(f_irqs, 0);
        chk(F_CNT_O, cnt);
        $display("test fetch_off end");
        O_MAX_I = 20'h0_0010;
        for (int t = 0; t < 4; t++) begin
            O_CLR_I = 1'b1;
            tick(1);
            O_CLR_I = 1'b0;
            O_EN_I  = 1'b1;
            tick(1);
            o_irqs  = 0;
            isu_pipe_i.op(va0, ~va0, va0, t[1:0], 1);
            chk(O_ARMED_O, 1'b1);
            if (t == 3) begin
                rearm_f(1'b0);
                fsample(48'h0000_0000_7770, 48'h0000_0000_8880, 3'h4, 1'b0);
            end
            tick(14);
            isu_pipe_i.op(va0 + t + 1, 48'h0000_0000_9990, 48'h0000_0000_AAA0, t[1:0], 3);
            tick(2);
            chk(o_irqs, 1);
            chk(O_RES_PARENT_O, va0 + t + 1);
            chk(O_RES_TYPE_O, t[1:0]);
            chk(O_RES_FLAGS_O, {t == 3, t == 1 || t == 2});
            chk(O_RES_TAG_RET_O, 16'h0006);
            if (t == 3) begin
                chk({O_RES_LS_VADDR_O[23:0], O_RES_LS_PADDR_O[23:0]}, 48'h0099_9000_AAA0);
                chk(O_RES_DC_LAT_O != LAT_RST, 1'b1);
                chk(F_RES_VADDR_O, 48'h0000_0000_7770);
            end else begin
                chk(O_RES_LS_VADDR_O | O_RES_LS_PADDR_O, ADDR_RST);
            end
            isu_pipe_i.op(~va0, va0, va0, t[1:0], 1);
            tick(2);
            chk(o_irqs, 1);
            chk(O_RES_PARENT_O, va0 + t + 1);
            O_EN_I = 1'b0;
            tick(1);
            $display("test op_type %0d end", t);
        end
        end_of_test();
    end
endmodule
